// ### verilog/lfm_defs.svh
// timing counts, levels and register layout of the LED driver fault manager
`ifndef LFM_DEFS_SVH
`define LFM_DEFS_SVH
`define LFM_CLK_HZ 40000000
`define LFM_BLANK_US 250
`define LFM_BLANK_CYC ((`LFM_BLANK_US * 40 + 0) )
`define LFM_GND_US 200
`define LFM_GND_CYC (`LFM_GND_US * 40)
`define LFM_BO_MS 25
`define LFM_BO_CYC (`LFM_BO_MS * 40000 + 1)
`define LFM_AUX_MS 90
`define LFM_AUX_CYC (`LFM_AUX_MS * 40000)
`define LFM_AR_S 4
`define LFM_AR_CYC (`LFM_AR_S * 40000000)
`define LFM_WOD_CNT 4
`define LFM_SCALE_FULL 8'h80
`define LFM_SCALE_HALF 8'h40
`define LFM_ADDR_STAT 4'h0
`define LFM_ADDR_MASK 4'h1
`define LFM_ADDR_CTRL 4'h2
`define LFM_ADDR_STATE 4'h3
`define LFM_ADDR_SCALE 4'h4
`endif

// ### verilog/lfm_pkg.sv
// types of the LED driver fault manager
package lfm_pkg;
  // fault event vector, one bit per cause
  typedef struct packed {
    logic gnd_open;
    logic cs_short;
    logic brownout;
    logic die_hot;
    logic wod;
    logic aux;
    logic programmable_overvoltage_trip;
    logic vcc_ovp;
    logic otp;
  } lfm_fault_type;
  typedef enum logic [2:0] {
    ST_OFF, ST_BLANK, ST_RUN, ST_AUTOREC, ST_LATCHED, ST_BROWNOUT, ST_HOLD
  } lfm_state_type;
endpackage : lfm_pkg

// ### verilog/lfm_timer.sv
// saturating qualify timer: asserts done after en held for LIMIT cycles
`timescale 1ns/1ps
`default_nettype none
module lfm_timer #(
  parameter int LIMIT = 10
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // control
  input wire logic en_i,
  output logic done_o
);
  initial begin
    if (LIMIT < 1) $error("lfm_timer LIMIT must be at least 1");
  end
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_r;
  // counts while enabled, clears at once when enable drops
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !en_i) begin
      cnt_r <= '0;
      done_o <= 1'b0;
    end else if (cnt_r != W'(LIMIT)) begin
      cnt_r <= cnt_r + 1'b1;
      done_o <= (cnt_r == W'(LIMIT - 1));
    end
  end
endmodule : lfm_timer
`default_nettype wire

// ### verilog/lfm_fault_mgr.sv
// fault sequencing, foldback and drive gating of the LED driver controller
//
// Contract
// [R1] thermal-sense below begin level lowers current target down to half at end level
// [R2] overtemperature trip faults; no resume until release level is exceeded; latching variant leaves ST_LATCHED on vcc_clear with no release check
// [R3] latching variant also needs supply below clear level after overtemperature
// [R4] overtemperature comparator ignored at least 250 us after supply start
// [R5] brown-out only after line-sense low continuously beyond 25 ms
// [R6] resume after brown-out once line-sense released and supply above start
// [R7] brown-out recovery drops to startup current and restarts at start level
// [R8] die overheat stops drive until the overheat flag clears
// [R9] check current-sense impedance at startup and after max on-time pulses
// [R10] ground-open flag held 200 us stops gate-drive pulses
// [R11] every major fault interrupts gate-drive pulses
// [R12] latching fault holds drive off until supply falls below clear level
// [R13] auto-recovery fault blocks drive 4 s, then restart at start level
// [R14] latching variant latches aux, winding, thermal overtemp and overvoltage faults
// [R15] valley-detect low 90 ms raises auxiliary short fault
// [R16] four consecutive overcurrent periods raise winding or diode short fault
// [R17] variant input selects behaviour; supply overvoltage and overheat never latch
// [R18] foldback scale moves monotonically from full to half across the band
`timescale 1ns/1ps
`default_nettype none
`include "lfm_defs.svh"
module lfm_fault_mgr
  import lfm_pkg::*;
#(
  parameter int BLANK_CYC = `LFM_BLANK_CYC,
  parameter int GND_CYC = `LFM_GND_CYC,
  parameter int BO_CYC = `LFM_BO_CYC,
  parameter int AUX_CYC = `LFM_AUX_CYC,
  parameter int AR_CYC = `LFM_AR_CYC,
  parameter logic [7:0] FB_BEGIN = 8'hC0,
  parameter logic [7:0] FB_END = 8'h80
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // variant select, high for latching
  input wire logic latch_variant_i,
  // comparator flags from the analog front end
  input wire logic vcc_start_i,
  input wire logic vcc_clear_i,
  input wire logic vcc_ovp_i,
  input wire logic otp_trip_i,
  input wire logic otp_release_i,
  input wire logic programmable_overvoltage_trip_trip_i,
  input wire logic bo_trip_i,
  input wire logic bo_release_i,
  input wire logic die_hot_i,
  input wire logic cs_low_z_i,
  input wire logic gnd_open_i,
  input wire logic valley_high_i,
  input wire logic cs_over_i,
  input wire logic period_end_i,
  input wire logic max_ton_end_i,
  input wire logic [7:0] thermal_code_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // drive and supply outputs
  output logic drive_en_o,
  output logic startup_current_o,
  output logic [7:0] fb_scale_o,
  output logic irq_o
);
  initial begin
    if (FB_BEGIN <= FB_END) $error("foldback begin code must exceed end code");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NIN = 16;
  logic [NIN-1:0] meta_r;
  logic [NIN-1:0] sync_r;
  logic [7:0] code_meta_r;
  logic [7:0] code_r;
  // two flops on every pin-domain input before any logic reads it
  always_ff @(posedge mclk_i) begin
    meta_r <= {latch_variant_i, vcc_start_i, vcc_clear_i, vcc_ovp_i, otp_trip_i,
               otp_release_i, programmable_overvoltage_trip_trip_i, bo_trip_i, bo_release_i, die_hot_i,
               cs_low_z_i, gnd_open_i, valley_high_i, cs_over_i, period_end_i,
               max_ton_end_i};
    sync_r <= meta_r;
    code_meta_r <= thermal_code_i;
    code_r <= code_meta_r;
  end
  wire latch_v = sync_r[15];
  wire vcc_start = sync_r[14];
  wire vcc_clear = sync_r[13];
  wire vcc_ovp = sync_r[12];
  wire otp_trip = sync_r[11];
  wire otp_release = sync_r[10];
  wire programmable_overvoltage_trip = sync_r[9];
  wire bo_low = sync_r[8];
  wire bo_release = sync_r[7];
  wire die_hot = sync_r[6];
  wire cs_low_z = sync_r[5];
  wire gnd_open = sync_r[4];
  wire valley_high = sync_r[3];
  wire cs_over = sync_r[2];
  wire period_end = sync_r[1];
  wire max_ton_end = sync_r[0];

  // ---------------------------------------------------------------
  // state and timers
  // ---------------------------------------------------------------
  lfm_state_type state_r;
  lfm_state_type state_nxt;
  logic [$clog2(`LFM_AR_CYC + 1)-1:0] ar_cnt_r;
  logic [$clog2(`LFM_BLANK_CYC + 1)-1:0] blank_cnt_r;
  logic [2:0] wod_cnt_r;
  logic wod_fault_r;
  logic max_ton_d_r;
  logic cs_check_r;
  logic otp_hold_r;
  logic die_hold_r;
  logic ctrl_force_off_r;
  logic [8:0] stat_r;
  logic [8:0] mask_r;
  wire run_like = (state_r == ST_RUN);
  wire bo_done;
  wire aux_done;
  wire gnd_done;
  wire ar_done = (ar_cnt_r == '0);
  wire blank_done = (blank_cnt_r == '0);

  // [R5] brown-out blanking
  lfm_timer #(.LIMIT(BO_CYC)) u_bo_tmr (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(bo_low && run_like), .done_o(bo_done));
  // [R15] valley-detect short timer
  lfm_timer #(.LIMIT(AUX_CYC)) u_aux_tmr (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(!valley_high && run_like),
    .done_o(aux_done));
  // [R10] ground-open qualify
  lfm_timer #(.LIMIT(GND_CYC)) u_gnd_tmr (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(gnd_open), .done_o(gnd_done));

  // ---------------------------------------------------------------
  // fault decode
  // ---------------------------------------------------------------
  // [R16] count consecutive overcurrent periods; a clean period restarts
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !run_like) begin
      wod_cnt_r <= 3'h0;
      wod_fault_r <= 1'b0;
    end else if (period_end) begin
      wod_cnt_r <= cs_over ? ((wod_cnt_r == 3'h4) ? 3'h4 : wod_cnt_r + 3'h1) : 3'h0;
      wod_fault_r <= cs_over && (wod_cnt_r == 3'(`LFM_WOD_CNT - 1));
    end
  end

  // [R9] impedance check at startup and after each max on-time pulse end
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      max_ton_d_r <= 1'b0;
      cs_check_r <= 1'b0;
    end else begin
      max_ton_d_r <= max_ton_end;
      cs_check_r <= (state_r == ST_BLANK) || (max_ton_end && !max_ton_d_r);
    end
  end

  // [R4] overtemperature ignored while blanking
  wire otp_seen = otp_trip && (state_r != ST_BLANK);
  lfm_fault_type fault;
  assign fault.otp = otp_seen;
  assign fault.vcc_ovp = vcc_ovp;
  assign fault.programmable_overvoltage_trip = programmable_overvoltage_trip;
  assign fault.wod = wod_fault_r;
  assign fault.aux = aux_done;
  assign fault.die_hot = die_hot;
  assign fault.brownout = bo_done;
  assign fault.cs_short = cs_check_r && cs_low_z;
  assign fault.gnd_open = gnd_done;
  // [R14] latching causes in the latching variant only
  // [R17] supply overvoltage and die overheat never latch
  wire latching = latch_v && (fault.otp || fault.programmable_overvoltage_trip || fault.wod || fault.aux);
  // [R11] any major fault stops pulsing
  wire major = fault.otp || fault.vcc_ovp || fault.programmable_overvoltage_trip || fault.wod || fault.aux ||
               fault.cs_short || fault.gnd_open;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (vcc_start && !die_hot && !ctrl_force_off_r) state_nxt = ST_BLANK;
      end
      ST_BLANK: begin
        if (die_hot) state_nxt = ST_HOLD;
        else if (blank_done) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        // [R8] overheat holds drive off until it clears
        if (die_hot) state_nxt = ST_HOLD;
        // [R12] latching fault
        else if (latching) state_nxt = ST_LATCHED;
        // [R13] auto-recovery fault
        else if (major) state_nxt = ST_AUTOREC;
        else if (fault.brownout) state_nxt = ST_BROWNOUT;
        else if (ctrl_force_off_r) state_nxt = ST_OFF;
      end
      ST_AUTOREC: begin
        // [R2] release level must be seen before resuming
        if (ar_done && !otp_hold_r) state_nxt = ST_OFF;
      end
      ST_LATCHED: begin
        // [R3] supply must fall below clear level
        if (vcc_clear) state_nxt = ST_OFF;
      end
      ST_BROWNOUT: begin
        // [R6] resume on line release with supply above start
        // [R7] startup current until start level is reached
        if (bo_release && vcc_start) state_nxt = ST_BLANK;
      end
      ST_HOLD: begin
        if (!die_hold_r) state_nxt = ST_OFF;
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // state register, recovery delay and blanking counters
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_OFF;
      ar_cnt_r <= '0;
      blank_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      ar_cnt_r <= (state_nxt == ST_AUTOREC && state_r != ST_AUTOREC) ?
                  $bits(ar_cnt_r)'(AR_CYC - 1) : (ar_done ? ar_cnt_r : ar_cnt_r - 1'b1);
      blank_cnt_r <= (state_nxt == ST_BLANK && state_r != ST_BLANK) ?
                     $bits(blank_cnt_r)'(BLANK_CYC - 1) :
                     (blank_done ? blank_cnt_r : blank_cnt_r - 1'b1);
    end
  end

  // [R2] hold overtemperature until release level; [R8] hold overheat until clear
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      otp_hold_r <= 1'b0;
      die_hold_r <= 1'b0;
    end else begin
      otp_hold_r <= fault.otp ? 1'b1 : (otp_release ? 1'b0 : otp_hold_r);
      die_hold_r <= die_hot;
    end
  end

  // ---------------------------------------------------------------
  // foldback scale
  // ---------------------------------------------------------------
  // [R18] linear map of the band to full..half, clamped at both ends
  function automatic logic [7:0] fb_map(input logic [7:0] code);
    logic [15:0] num;
    num = 16'h0000;
    if (code >= FB_BEGIN) return `LFM_SCALE_FULL;
    if (code <= FB_END) return `LFM_SCALE_HALF;
    num = 16'(code - FB_END) * 16'(`LFM_SCALE_FULL - `LFM_SCALE_HALF);
    return 8'(`LFM_SCALE_HALF + num / 16'(FB_BEGIN - FB_END));
  endfunction : fb_map

  // ---------------------------------------------------------------
  // registers: 0 status (read clears), 1 mask, 2 control, 3 state, 4 scale
  // ---------------------------------------------------------------
  wire rd_stat = rd_i && (addr_i == `LFM_ADDR_STAT);
  wire [8:0] ev = fault;
  wire [15:0] rd_mux =
    (addr_i == `LFM_ADDR_STAT) ? {7'h00, stat_r} :
    (addr_i == `LFM_ADDR_MASK) ? {7'h00, mask_r} :
    (addr_i == `LFM_ADDR_CTRL) ? {15'h0000, ctrl_force_off_r} :
    (addr_i == `LFM_ADDR_STATE) ? {13'h0000, state_r} :
    (addr_i == `LFM_ADDR_SCALE) ? {8'h00, fb_scale_o} : 16'h0000;

  // sticky status: a new event wins over the read clear
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      stat_r <= 9'h000;
      mask_r <= 9'h000;
      ctrl_force_off_r <= 1'b0;
      rdata_o <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      stat_r <= (rd_stat ? 9'h000 : stat_r) | ev;
      if (wr_i && addr_i == `LFM_ADDR_MASK) mask_r <= wdata_i[8:0];
      if (wr_i && addr_i == `LFM_ADDR_CTRL) ctrl_force_off_r <= wdata_i[0];
      rdata_o <= rd_i ? rd_mux : 16'h0000;
      irq_o <= |(((rd_stat ? 9'h000 : stat_r) | ev) & mask_r);
    end
  end

  // registered drive outputs
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      drive_en_o <= 1'b0;
      startup_current_o <= 1'b1;
      fb_scale_o <= `LFM_SCALE_FULL;
    end else begin
      // [R11] pulses only while running clean
      drive_en_o <= (state_nxt == ST_RUN);
      // [R7] startup consumption while waiting on supply
      startup_current_o <= (state_nxt != ST_RUN) && (state_nxt != ST_BLANK);
      // [R1] foldback request
      fb_scale_o <= fb_map(code_r);
    end
  end
endmodule : lfm_fault_mgr
`default_nettype wire

// ### dv/lfm_fault_mgr_monitor.sv
// port checker of the LED driver fault manager
`timescale 1ns/1ps
`default_nettype none
module lfm_fault_mgr_monitor #(
  parameter int BLANK_CYC = 20,
  parameter int GND_CYC = 20,
  parameter int BO_CYC = 50,
  parameter logic [7:0] FB_BEGIN = 8'hC0,
  parameter logic [7:0] FB_END = 8'h80
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // fault flags
  input wire logic vcc_ovp_i,
  input wire logic otp_trip_i,
  input wire logic programmable_overvoltage_trip_trip_i,
  input wire logic die_hot_i,
  input wire logic bo_trip_i,
  input wire logic gnd_open_i,
  input wire logic [7:0] thermal_code_i,
  // watched outputs
  input wire logic drive_en_o,
  input wire logic startup_current_o,
  input wire logic [7:0] fb_scale_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // run lengths of the qualified flags; slack covers the input synchronisers
  logic [7:0] gnd_run_r;
  logic [7:0] bo_run_r;
  always_ff @(posedge mclk_i) begin
    gnd_run_r <= gnd_open_i ? gnd_run_r + {7'h00, gnd_run_r != 8'hFF} : 8'h00;
    bo_run_r <= bo_trip_i ? bo_run_r + {7'h00, bo_run_r != 8'hFF} : 8'h00;
  end
  chk_ovp_gate: assert property (vcc_ovp_i |-> ##[1:6] !drive_en_o)
    else $error("drive kept after supply overvoltage");
  chk_programmable_overvoltage_trip_gate: assert property (programmable_overvoltage_trip_trip_i |-> ##[1:6] !drive_en_o)
    else $error("drive kept after programmable overvoltage");
  chk_otp_gate: assert property (otp_trip_i |-> ##[1:6] !drive_en_o)
    else $error("drive kept after overtemperature");
  chk_die_hot_gate: assert property (die_hot_i |-> ##[1:6] !drive_en_o)
    else $error("drive kept after die overheat");
  chk_blank_len: assert property ($rose(drive_en_o) |-> $past(!startup_current_o, BLANK_CYC - 2))
    else $error("blanking shorter than its count");
  chk_gnd_qual: assert property (gnd_run_r > GND_CYC + 8 |-> !drive_en_o)
    else $error("drive kept after ground open");
  chk_bo_early: assert property ($fell(drive_en_o) && bo_trip_i |-> bo_run_r >= BO_CYC)
    else $error("brownout declared too early");
  chk_bo_late: assert property (bo_run_r == BO_CYC + 8 |-> !drive_en_o)
    else $error("brownout not declared");
  chk_run_current: assert property (drive_en_o |-> !startup_current_o)
    else $error("startup current while driving");
  chk_scale_end: assert property ((thermal_code_i <= FB_END) [*6] |-> fb_scale_o == 8'h40)
    else $error("scale not half at end level");
  chk_scale_full: assert property ((thermal_code_i >= FB_BEGIN) [*6] |-> fb_scale_o == 8'h80)
    else $error("scale not full above begin level");
  cover property ($fell(drive_en_o) && bo_trip_i);
  cover property ($rose(drive_en_o));
  cover property (irq_o && die_hot_i);
endmodule : lfm_fault_mgr_monitor
bind lfm_fault_mgr lfm_fault_mgr_monitor #(.BLANK_CYC(BLANK_CYC), .GND_CYC(GND_CYC),
  .BO_CYC(BO_CYC), .FB_BEGIN(FB_BEGIN), .FB_END(FB_END)) u_mon (.mclk_i(mclk_i),
  .reset_n_i(reset_n_i), .vcc_ovp_i(vcc_ovp_i), .otp_trip_i(otp_trip_i),
  .programmable_overvoltage_trip_trip_i(programmable_overvoltage_trip_trip_i), .die_hot_i(die_hot_i), .bo_trip_i(bo_trip_i),
  .gnd_open_i(gnd_open_i), .thermal_code_i(thermal_code_i), .drive_en_o(drive_en_o),
  .startup_current_o(startup_current_o), .fb_scale_o(fb_scale_o), .irq_o(irq_o));
`default_nettype wire

// ### dv/lfm_plant.sv
// far-side model: power stage switching and sense comparators
`timescale 1ns/1ps
`default_nettype none
module lfm_plant (
  // clock and gate drive
  input wire logic mclk_i,
  input wire logic drive_en_i,
  // injected board faults
  input wire logic aux_short_i,
  input wire logic wind_short_i,
  input wire logic long_ton_i,
  // sense flags towards the controller
  output logic valley_high_o,
  output logic cs_over_o,
  output logic period_end_o,
  output logic max_ton_end_o
);
  // four-cycle switching period; all flags fall silent while the gate is off
  logic [1:0] ph_r = 2'h0;
  always_ff @(posedge mclk_i) ph_r <= ph_r + 2'h1;
  assign period_end_o = drive_en_i && ph_r == 2'h3;
  // a shorted aux winding never rings above the valley threshold
  assign valley_high_o = drive_en_i && !aux_short_i && ph_r == 2'h1;
  assign cs_over_o = drive_en_i && wind_short_i;
  assign max_ton_end_o = drive_en_i && long_ton_i && ph_r[1];
endmodule : lfm_plant
`default_nettype wire

// ### dv/tb_lfm_fault_mgr.sv
// self-checking bench of the LED driver fault manager
`timescale 1ns/1ps
`default_nettype none
module tb_lfm_fault_mgr;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic latch_variant_i = 1'b0;
  logic vcc_start_i = 1'b0;
  logic vcc_clear_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [8:0] fi = 9'h000; // injected faults in status bit order
  logic [7:0] thermal_code_i = 8'hFF;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  wire logic [15:0] rdata_o;
  wire logic [7:0] fb_scale_o;
  wire logic drive_en_o, startup_current_o, irq_o;
  wire logic valley_high_i, cs_over_i, period_end_i, max_ton_end_i;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] tc[5] = '{8'hFF, 8'hC0, 8'hA0, 8'h80, 8'h00};
  logic [7:0] lo[5] = '{8'h80, 8'h80, 8'h41, 8'h40, 8'h40};
  logic [7:0] hi[5] = '{8'h80, 8'h80, 8'h7F, 8'h40, 8'h40};
  int pb[2] = '{6, 8};
  int pw[2] = '{40, 10};
  always #12.5 mclk_i = !mclk_i;
  lfm_fault_mgr #(.BLANK_CYC(20), .GND_CYC(20), .BO_CYC(50), .AUX_CYC(50), .AR_CYC(100)) dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .latch_variant_i(latch_variant_i),
    .vcc_start_i(vcc_start_i), .vcc_clear_i(vcc_clear_i), .vcc_ovp_i(fi[1]),
    .otp_trip_i(fi[0]), .otp_release_i(!fi[0]), .programmable_overvoltage_trip_trip_i(fi[2]), .bo_trip_i(fi[6]),
    .bo_release_i(!fi[6]), .die_hot_i(fi[5]), .cs_low_z_i(fi[7]), .gnd_open_i(fi[8]),
    .valley_high_i(valley_high_i), .cs_over_i(cs_over_i), .period_end_i(period_end_i),
    .max_ton_end_i(max_ton_end_i), .thermal_code_i(thermal_code_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .drive_en_o(drive_en_o),
    .startup_current_o(startup_current_o), .fb_scale_o(fb_scale_o), .irq_o(irq_o));
  lfm_plant plant (.mclk_i(mclk_i), .drive_en_i(drive_en_o), .aux_short_i(fi[3]),
    .wind_short_i(fi[4]), .long_ton_i(fi[7]), .valley_high_o(valley_high_i),
    .cs_over_o(cs_over_i), .period_end_o(period_end_i), .max_ton_end_o(max_ton_end_i));
  // values read right after an edge are the settled ones from before it
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    cyc(1);
    rd_i <= 1'b0;
    cyc(1);
    d = rdata_o;
  endtask : rd_reg
  task automatic wait_drv(input logic v, input int lim);
    for (int k = 0; k < lim && drive_en_o !== v; k++) cyc(1);
    check(drive_en_o, v);
  endtask : wait_drv
  // one fault cause in one variant: trip, status, irq, hold, recovery
  task automatic run_case(input int v, input int i);
    logic [15:0] d;
    logic [2:0] es;
    es = (i == 5) ? 3'd6 : (i == 6) ? 3'd5 : (i > 6) ? 3'd7 : (v == 1 && i != 1) ? 3'd4 : 3'd3;
    latch_variant_i <= v[0];
    wr_reg(4'h1, 16'h0000);
    rd_reg(4'h0, d);
    fi <= 9'h001 << i;
    wait_drv(1'b0, 120);
    cyc(4);
    // sticky bit is set but masked, so no interrupt yet
    check(irq_o, 1'b0);
    wr_reg(4'h1, 16'h01FF);
    cyc(2);
    check(irq_o, 1'b1);
    rd_reg(4'h0, d);
    check(d[i], 1'b1);
    rd_reg(4'h3, d);
    if (es != 3'd7) check(d[2:0], es);
    cyc(30);
    check(drive_en_o, 1'b0);
    if (es == 3'd5) check(startup_current_o, 1'b1);
    fi <= 9'h000;
    if (es == 3'd4) begin
      cyc(120);
      check(drive_en_o, 1'b0);
      vcc_start_i <= 1'b0;
      vcc_clear_i <= 1'b1;
      cyc(5);
      vcc_start_i <= 1'b1;
      vcc_clear_i <= 1'b0;
    end
    wait_drv(1'b1, 300);
    $display("case %0d variant %0d done", i, v);
  endtask : run_case
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // watchdog sized well above the expected run of about 3000 cycles
  initial begin
    #(30000 * 25);
    mismatches++;
    final_report();
  end
  initial begin
    logic [15:0] d;
    cyc(12);
    reset_n_i <= 1'b1;
    cyc(2);
    // supply up while the thermal trip is high inside the blanking window
    vcc_clear_i <= 1'b0;
    vcc_start_i <= 1'b1;
    fi <= 9'h001;
    cyc(14);
    fi <= 9'h000;
    wait_drv(1'b1, 60);
    rd_reg(4'h3, d);
    check(d, 16'h0002);
    wr_reg(4'h1, 16'h01FF);
    rd_reg(4'h1, d);
    check(d, 16'h01FF);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, d);
    check(d, 16'h0000);
    $display("startup and registers done");
    foreach (tc[j]) begin
      thermal_code_i <= tc[j];
      cyc(8);
      check(fb_scale_o >= lo[j] && fb_scale_o <= hi[j], 1'b1);
    end
    rd_reg(4'h4, d);
    check(d, 16'h0040);
    thermal_code_i <= 8'hFF;
    $display("foldback done");
    // flags shorter than their qualify time must not stop the drive
    foreach (pb[j]) begin
      fi <= 9'h001 << pb[j];
      cyc(pw[j]);
      fi <= 9'h000;
      cyc(10);
      check(drive_en_o, 1'b1);
    end
    $display("short glitches done");
    // software force-off stops the drive and a clear lets it restart
    wr_reg(4'h2, 16'h0001);
    wait_drv(1'b0, 10);
    rd_reg(4'h2, d);
    check(d, 16'h0001);
    wr_reg(4'h2, 16'h0000);
    wait_drv(1'b1, 60);
    $display("force off done");
    for (int v = 0; v < 2; v++) for (int i = 0; i < 9; i++) run_case(v, i);
    final_report();
  end
endmodule : tb_lfm_fault_mgr
`default_nettype wire
